// [hdl/lcr_defs.svh]
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH

// Register byte addresses
`define LCR_SET_OFF       8'he0
`define LCR_CLR_OFF       8'he4

// Field positions
`define LCR_SRC_BIT       22
`define LCR_MASTER_BIT    21
`define LCR_TMR_EN_BIT    20
`define LCR_PHY_BIT       10
`define LCR_SID_BIT       9
`define LCR_LOCK_BIT      6

// Masks and reset value
`define LCR_RESET_VAL     32'h0000_0000
`define LCR_WR_MASK       32'h0070_0640
`define LCR_CLR_MASK      32'h0070_0600
`define LCR_RSV_MASK      32'hff8f_f9bf

// Timing: one cycle is 125 us of the 24.576 MHz timer clock
`define LCR_CYCLE_NS      125000
`define LCR_TMR_CLK_KHZ   24576
`define LCR_ROLL_COUNT    ((`LCR_CYCLE_NS * `LCR_TMR_CLK_KHZ) / 1000000)

`endif

// [hdl/lcr_pkg.sv]
package lcr_pkg;

  typedef enum logic [1:0] {
    LCR_PKT_NONE  = 2'b00,
    LCR_PKT_PHY   = 2'b01,
    LCR_PKT_SID   = 2'b10,
    LCR_PKT_CYCST = 2'b11
  } lcr_pkt_kind_t;

  typedef struct packed {
    logic          valid;
    lcr_pkt_kind_t kind;
  } lcr_rx_pkt_t;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
    logic        phy_acc;
    logic        sid_acc;
    logic        cs_acc;
    logic        cs_send;
  } lcr_top_state_t;

  typedef struct packed {
    logic [11:0] offset;
    logic        ext_prev;
    logic        roll;
  } lcr_tmr_state_t;

endpackage

// [hdl/lcr_cycle_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.svh"

module lcr_cycle_timer
  import lcr_pkg::*;
#(
  parameter int ROLL_COUNT = `LCR_ROLL_COUNT
)
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        enable,
  input  wire logic        ext_source,
  input  wire logic        external_rollover_input,
  // Timer state
  output logic [11:0]      offset,
  output logic             rollover
);

  localparam logic [11:0] LAST = 12'(ROLL_COUNT - 1);

  lcr_tmr_state_t st_ff;
  lcr_tmr_state_t nxt_st;
  logic           ext_rise;
  logic           roll_now;

  if (ROLL_COUNT < 2 || ROLL_COUNT > 4096)
  begin : g_bad_count
    $error("ROLL_COUNT must lie in 2..4096");
  end

  // Pin is synchronous to hclk, so only an edge detector is needed
  assign ext_rise = external_rollover_input & ~st_ff.ext_prev;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ext_prev = external_rollover_input;
    roll_now = enable & (ext_source ? ext_rise : (st_ff.offset == LAST));
    nxt_st.roll = roll_now;
    if (!enable)
    begin
      nxt_st.offset = st_ff.offset;
    end
    else if (roll_now)
    begin
      nxt_st.offset = 12'h000;
    end
    else if (st_ff.offset != LAST)
    begin
      // External source waits at the last count for a late pin edge
      nxt_st.offset = st_ff.offset + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign offset   = st_ff.offset;
  assign rollover = st_ff.roll;

  a_ext_roll: assert property (@(posedge hclk) disable iff (!hresetn)
    enable && ext_source && external_rollover_input && !st_ff.ext_prev
    |=> rollover && offset == 12'h000)
    else $error("external pin edge did not roll the timer");

  a_int_roll: assert property (@(posedge hclk) disable iff (!hresetn)
    enable && !ext_source && offset == LAST |=> rollover && offset == 12'h000)
    else $error("internal count did not roll at the last count");

  a_offset_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> $stable(offset) && !rollover)
    else $error("offset moved while counting was off");

endmodule
`default_nettype wire

// [hdl/lcr_sync_filter_bank.sv]
`timescale 1ns/1ps
`default_nettype none

module lcr_sync_filter_bank
  import lcr_pkg::*;
#(
  parameter int NUM_CTX = 4
)
(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Control
  input  wire logic               lock,
  // Match register writes
  input  wire logic [NUM_CTX-1:0] wr_en,
  input  wire logic [NUM_CTX-1:0] wr_data,
  // Filter bits
  output logic [NUM_CTX-1:0]      filter
);

  logic [NUM_CTX-1:0] filter_ff;
  logic [NUM_CTX-1:0] nxt_filter;

  if (NUM_CTX < 1 || NUM_CTX > 32)
  begin : g_bad_ctx
    $error("NUM_CTX must lie in 1..32");
  end

  for (genvar i = 0; i < NUM_CTX; i++)
  begin : g_ctx
    // Lock overrides any software write in the same cycle
    assign nxt_filter[i] = lock | (wr_en[i] ? wr_data[i] : filter_ff[i]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filter_ff <= '0;
    end
    else
    begin
      filter_ff <= nxt_filter;
    end
  end

  assign filter = filter_ff;

  a_lock_force: assert property (@(posedge hclk) disable iff (!hresetn)
    lock |=> &filter)
    else $error("sync filter bit not forced while locked");

  a_free_write: assert property (@(posedge hclk) disable iff (!hresetn)
    !lock && wr_en[0] |=> filter[0] == $past(wr_data[0]))
    else $error("sync filter write lost while unlocked");

endmodule
`default_nettype wire

// [hdl/lcr_link_ctrl.sv]
// What this block does
// - Reserved bits 31-23, 19-11, 8-7 and 5-0 always read as zero.
// - With rollover source set, the external pin rolls the cycle timer over.
// - With rollover source clear, the timer rolls over after 3072 counts.
// - Cycle master and root: one cycle start packet per rollover.
// - Not root: received cycle start packets are accepted regardless of master bit.
// - Overlong cycle flag set clears the cycle master bit automatically.
// - Setting cycle master is ignored while the overlong cycle flag is set.
// - Offset counts while the count enable is set, holds while clear.
// - PHY packets accepted only with their bit and request context enabled.
// - Self-ID packets accepted only while the self-ID bit is set.
// - Lock set forces the sync filter bit of every receive context.
// - Lock clear lets software write each sync filter bit freely.
// - Lock bit is set by software only; cleared only by resets.
// - Ones written at the set address set bits, at the clear address clear.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.svh"

module lcr_link_ctrl
  import lcr_pkg::*;
#(
  parameter int NUM_CTX    = 4,
  parameter int ROLL_COUNT = `LCR_ROLL_COUNT
)
(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               global_device_reset,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Link status
  input  wire logic               is_root,
  input  wire logic               external_rollover_input,
  input  wire logic               overlong_cycle_flag,
  input  wire logic               ar_req_ctx_enable,
  // Received packets
  input  wire lcr_rx_pkt_t        rx_pkt,
  output logic                    phy_pkt_accept,
  output logic                    self_id_accept,
  output logic                    cycle_start_accept,
  // Cycle timer
  output logic                    cycle_start_send,
  output logic [11:0]             cycle_offset,
  output logic                    cycle_rollover,
  // Receive context match registers
  input  wire logic [NUM_CTX-1:0] ir_match_wr_en,
  input  wire logic [NUM_CTX-1:0] ir_match_wr_data,
  output logic [NUM_CTX-1:0]      ir_sync_filter_bit
);

  lcr_top_state_t st_ff;
  lcr_top_state_t nxt_st;
  logic           addr_take;
  logic           rollover_source_select;
  logic           cycle_master_enable;
  logic           offset_count_enable;
  logic           receive_phy_packets;
  logic           receive_self_id_packets;
  logic           sync_filter_force_lock;
  logic [31:0]    set_bits;
  logic [31:0]    clr_bits;

  if (NUM_CTX < 1 || NUM_CTX > 32)
  begin : g_bad_ctx
    $error("NUM_CTX must lie in 1..32");
  end

  // Word decode of the low address byte, shared by set, clear and read paths
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
    hits = (addr[7:2] == off[7:2]);
  endfunction

  assign rollover_source_select  = st_ff.ctrl[`LCR_SRC_BIT];
  assign cycle_master_enable     = st_ff.ctrl[`LCR_MASTER_BIT];
  assign offset_count_enable     = st_ff.ctrl[`LCR_TMR_EN_BIT];
  assign receive_phy_packets     = st_ff.ctrl[`LCR_PHY_BIT];
  assign receive_self_id_packets = st_ff.ctrl[`LCR_SID_BIT];
  assign sync_filter_force_lock  = st_ff.ctrl[`LCR_LOCK_BIT];

  // Zero-wait slave: every valid address phase is taken while hready is high
  assign addr_take = hsel & htrans[1] & hready;

  always_comb
  begin
    nxt_st = st_ff;
    set_bits = 32'h0000_0000;
    clr_bits = 32'h0000_0000;
    nxt_st.ready = 1'b1;
    nxt_st.resp = 1'b0;

    // Data phase of a write: only ones act, zeros leave bits alone
    if (st_ff.wr_pend)
    begin
      if (hits(st_ff.wr_addr, `LCR_SET_OFF))
      begin
        set_bits = hwdata & `LCR_WR_MASK;
      end
      if (hits(st_ff.wr_addr, `LCR_CLR_OFF))
      begin
        // Lock bit is absent from the clear mask, so software cannot drop it
        clr_bits = hwdata & `LCR_CLR_MASK;
      end
    end

    if (overlong_cycle_flag)
    begin
      set_bits[`LCR_MASTER_BIT] = 1'b0;
    end

    nxt_st.ctrl = (st_ff.ctrl | set_bits) & ~clr_bits;
    nxt_st.ctrl = nxt_st.ctrl & ~`LCR_RSV_MASK;

    // Hardware clear beats a software set landing in the same cycle
    if (overlong_cycle_flag)
    begin
      nxt_st.ctrl[`LCR_MASTER_BIT] = 1'b0;
    end

    if (global_device_reset)
    begin
      nxt_st.ctrl = `LCR_RESET_VAL;
    end

    // Address phase
    nxt_st.wr_pend = addr_take & hwrite;
    nxt_st.wr_addr = haddr[7:0];
    nxt_st.rdata = 32'h0000_0000;
    if (addr_take && !hwrite &&
        (hits(haddr[7:0], `LCR_SET_OFF) || hits(haddr[7:0], `LCR_CLR_OFF)))
    begin
      // Next value is read so a write just before the read is visible
      nxt_st.rdata = nxt_st.ctrl & ~`LCR_RSV_MASK;
    end

    // Packet gating
    nxt_st.phy_acc = rx_pkt.valid && rx_pkt.kind == LCR_PKT_PHY &&
                     receive_phy_packets && ar_req_ctx_enable;
    nxt_st.sid_acc = rx_pkt.valid && rx_pkt.kind == LCR_PKT_SID &&
                     receive_self_id_packets;
    nxt_st.cs_acc  = rx_pkt.valid && rx_pkt.kind == LCR_PKT_CYCST &&
                     !is_root;

    // One cycle start per rollover; source choice lives in the timer
    nxt_st.cs_send = cycle_rollover && cycle_master_enable && is_root;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= '0;
      st_ff.ctrl <= `LCR_RESET_VAL;
      st_ff.ready <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  lcr_cycle_timer #(
    .ROLL_COUNT (ROLL_COUNT)
  ) u_timer (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .enable                  (offset_count_enable),
    .ext_source              (rollover_source_select),
    .external_rollover_input (external_rollover_input),
    .offset                  (cycle_offset),
    .rollover                (cycle_rollover)
  );

  lcr_sync_filter_bank #(
    .NUM_CTX (NUM_CTX)
  ) u_filters (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lock    (sync_filter_force_lock),
    .wr_en   (ir_match_wr_en),
    .wr_data (ir_match_wr_data),
    .filter  (ir_sync_filter_bit)
  );

  assign hreadyout          = st_ff.ready;
  assign hresp              = st_ff.resp;
  assign hrdata             = st_ff.rdata;
  assign phy_pkt_accept     = st_ff.phy_acc;
  assign self_id_accept     = st_ff.sid_acc;
  assign cycle_start_accept = st_ff.cs_acc;
  assign cycle_start_send   = st_ff.cs_send;

  a_reserved_bits_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (hrdata & `LCR_RSV_MASK) == 32'h0000_0000)
    else $error("reserved bits read as one");

  a_cs_send: assert property (@(posedge hclk) disable iff (!hresetn)
    cycle_start_send == $past(cycle_rollover && cycle_master_enable && is_root))
    else $error("cycle start send not paired with rollover");

  a_cs_accept: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_pkt.valid && rx_pkt.kind == LCR_PKT_CYCST && !is_root |=> cycle_start_accept)
    else $error("cycle start not accepted while not root");

  a_master_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    overlong_cycle_flag |=> !cycle_master_enable)
    else $error("cycle master survived overlong cycle flag");

  // A set refused under the flag must not linger and land once the flag drops
  a_master_block: assert property (@(posedge hclk) disable iff (!hresetn)
    overlong_cycle_flag ##1 !(st_ff.wr_pend && hits(st_ff.wr_addr, `LCR_SET_OFF)
    && hwdata[`LCR_MASTER_BIT]) |=> !cycle_master_enable)
    else $error("cycle master set while overlong flag high");

  a_phy_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_pkt_accept |-> $past(receive_phy_packets) && $past(ar_req_ctx_enable))
    else $error("PHY packet accepted while gated off");

  a_sid_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_pkt.valid && rx_pkt.kind == LCR_PKT_SID
    |=> self_id_accept == $past(receive_self_id_packets))
    else $error("self-ID acceptance does not follow its bit");

  a_lock_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    sync_filter_force_lock && !global_device_reset |=> sync_filter_force_lock)
    else $error("lock bit cleared without reset");

  a_clr_write: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.wr_pend && hits(st_ff.wr_addr, `LCR_CLR_OFF) && hwdata[`LCR_SID_BIT]
    |=> !receive_self_id_packets)
    else $error("clear address did not clear the bit");

  a_zero_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.wr_pend && hits(st_ff.wr_addr, `LCR_SET_OFF) && !hwdata[`LCR_PHY_BIT]
    && !global_device_reset |=> $stable(receive_phy_packets))
    else $error("zero written at set address changed a bit");

  a_set_write: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.wr_pend && hits(st_ff.wr_addr, `LCR_SET_OFF) && hwdata[`LCR_PHY_BIT]
    && !global_device_reset |=> receive_phy_packets)
    else $error("set address did not set the bit");

  a_clr_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.wr_pend && hits(st_ff.wr_addr, `LCR_CLR_OFF) && !hwdata[`LCR_PHY_BIT]
    && !global_device_reset |=> $stable(receive_phy_packets))
    else $error("zero written at clear address changed a bit");

  a_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite
    && (hits(haddr[7:0], `LCR_SET_OFF) || hits(haddr[7:0], `LCR_CLR_OFF))
    |=> hrdata == st_ff.ctrl)
    else $error("read data differs from register contents");

  a_phy_no_sid: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_pkt.valid && rx_pkt.kind == LCR_PKT_SID |=> !phy_pkt_accept)
    else $error("self-ID packet taken into the PHY packet path");

  a_phy_accept: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_pkt.valid && rx_pkt.kind == LCR_PKT_PHY && receive_phy_packets
    && ar_req_ctx_enable |=> phy_pkt_accept)
    else $error("PHY packet dropped while enabled");

  a_sid_only: assert property (@(posedge hclk) disable iff (!hresetn)
    self_id_accept |-> $past(rx_pkt.valid && rx_pkt.kind == LCR_PKT_SID))
    else $error("self-ID accept without a self-ID packet");

  a_root_no_cs: assert property (@(posedge hclk) disable iff (!hresetn)
    is_root |=> !cycle_start_accept)
    else $error("cycle start accepted while root");

  a_no_send_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !cycle_master_enable |=> !cycle_start_send)
    else $error("cycle start sent without cycle master");

  a_gdr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    global_device_reset |=> st_ff.ctrl == `LCR_RESET_VAL)
    else $error("global reset did not clear the register");

  // Only a software set may raise the lock; nothing else in hardware does
  a_lock_no_soft: assert property (@(posedge hclk) disable iff (!hresetn)
    !sync_filter_force_lock && !(st_ff.wr_pend && hits(st_ff.wr_addr, `LCR_SET_OFF)
    && hwdata[`LCR_LOCK_BIT]) |=> !sync_filter_force_lock)
    else $error("lock bit rose without a software set");

endmodule
`default_nettype wire

// [verification/lcr_phy_model.sv]
`timescale 1ns/1ps
`default_nettype none

module lcr_phy_model
  import lcr_pkg::*;
(
  // Clock
  input  wire logic     hclk,
  // Toward the link
  output var lcr_rx_pkt_t rx_pkt,
  output var logic      is_root,
  output var logic      external_rollover_input
);
  initial
  begin
    rx_pkt = '0;
    is_root = 1'b0;
    external_rollover_input = 1'b0;
  end

  // Packets last exactly one clock, as the link side expects
  task automatic send(input lcr_pkt_kind_t k);
    rx_pkt <= '{valid: 1'b1, kind: k};
    @(posedge hclk);
    rx_pkt <= '0;
  endtask

  task automatic set_root(input logic v);
    is_root <= v;
    @(posedge hclk);
  endtask

  // One clock is enough: the pin is synchronous and only its rising edge counts
  task automatic pin_pulse();
    external_rollover_input <= 1'b1;
    @(posedge hclk);
    external_rollover_input <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import lcr_pkg::*;
  typedef struct packed {logic [31:0] wa; logic [31:0] wd;
                         logic [31:0] ra; logic [31:0] ex;} lcr_row_t;
  localparam int RC = 16;
  localparam lcr_row_t ROWS [8] = '{
    '{32'he0, 32'hffff_ffff, 32'he0, 32'h0070_0640},
    '{32'he4, 32'hffff_ffff, 32'he4, 32'h0000_0040},
    '{32'he0, 32'h0000_0000, 32'he0, 32'h0000_0040},
    '{32'he0, 32'h0000_0600, 32'he4, 32'h0000_0640},
    '{32'he4, 32'h0000_0200, 32'he0, 32'h0000_0440},
    '{32'he8, 32'hffff_ffff, 32'he4, 32'h0000_0440},
    '{32'he4, 32'h0000_0000, 32'he8, 32'h0000_0000},
    '{32'he4, 32'h0000_0400, 32'he0, 32'h0000_0040}};

  logic        hclk, hresetn, global_device_reset, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        overlong_cycle_flag, ar_req_ctx_enable, is_root, ext_pin;
  logic        phy_pkt_accept, self_id_accept, cycle_start_accept;
  logic        cycle_start_send, cycle_rollover;
  logic [11:0] cycle_offset;
  logic [3:0]  wr_en, wr_data, filt;
  logic [2:0]  seen;
  lcr_rx_pkt_t rx_pkt;
  int          fail_count, n_tests, cyc, n;

  lcr_phy_model phy (.hclk(hclk), .rx_pkt(rx_pkt), .is_root(is_root),
                     .external_rollover_input(ext_pin));

  lcr_link_ctrl #(.NUM_CTX(4), .ROLL_COUNT(RC)) dut (
    .hclk(hclk), .hresetn(hresetn), .global_device_reset(global_device_reset),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .is_root(is_root), .external_rollover_input(ext_pin),
    .overlong_cycle_flag(overlong_cycle_flag), .ar_req_ctx_enable(ar_req_ctx_enable),
    .rx_pkt(rx_pkt), .phy_pkt_accept(phy_pkt_accept), .self_id_accept(self_id_accept),
    .cycle_start_accept(cycle_start_accept), .cycle_start_send(cycle_start_send),
    .cycle_offset(cycle_offset), .cycle_rollover(cycle_rollover),
    .ir_match_wr_en(wr_en), .ir_match_wr_data(wr_data), .ir_sync_filter_bit(filt));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under two thousand clocks
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rdr(input logic [31:0] a, output logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Accept pulses are gathered over a short window; exact latency is asserted in the design
  task automatic pkt(input lcr_pkt_kind_t k);
    seen = 3'b000;
    phy.send(k);
    repeat (3)
    begin
      @(posedge hclk);
      seen = seen | {phy_pkt_accept, self_id_accept, cycle_start_accept};
    end
  endtask

  task automatic wait_roll();
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (cycle_rollover !== 1'b1 && n < 200);
  endtask

  initial
  begin
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    hresetn = 1'b0;
    global_device_reset = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    overlong_cycle_flag = 1'b0;
    ar_req_ctx_enable = 1'b1;
    wr_en = 4'h0;
    wr_data = 4'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdr(32'he0, rd);
    check("reset value", 32'h0, rd);
    foreach (ROWS[i])
    begin
      wr(ROWS[i].wa, ROWS[i].wd);
      rdr(ROWS[i].ra, rd);
      check("register row", ROWS[i].ex, rd);
    end
    wr_en <= 4'hf;
    wr_data <= 4'h0;
    @(posedge hclk);
    wr_en <= 4'h0;
    repeat (2) @(posedge hclk);
    check("locked filter", 32'hf, {28'h0, filt});
    global_device_reset <= 1'b1;
    @(posedge hclk);
    global_device_reset <= 1'b0;
    @(posedge hclk);
    rdr(32'he0, rd);
    check("after global reset", 32'h0, rd);
    wr_en <= 4'hf;
    wr_data <= 4'h5;
    @(posedge hclk);
    wr_en <= 4'h0;
    repeat (2) @(posedge hclk);
    check("free filter", 32'h5, {28'h0, filt});
    wr(32'he0, 32'h0000_0600);
    pkt(LCR_PKT_PHY);
    check("phy accepted", 32'h4, {29'h0, seen});
    pkt(LCR_PKT_SID);
    check("self id accepted", 32'h2, {29'h0, seen});
    pkt(LCR_PKT_CYCST);
    check("cycle start accepted", 32'h1, {29'h0, seen});
    ar_req_ctx_enable <= 1'b0;
    pkt(LCR_PKT_PHY);
    check("phy without context", 32'h0, {29'h0, seen});
    ar_req_ctx_enable <= 1'b1;
    wr(32'he4, 32'h0000_0400);
    pkt(LCR_PKT_SID);
    check("self id without phy bit", 32'h2, {29'h0, seen});
    wr(32'he4, 32'h0000_0200);
    pkt(LCR_PKT_SID);
    check("self id refused", 32'h0, {29'h0, seen});
    phy.set_root(1'b1);
    wr(32'he0, 32'h0030_0000);
    wait_roll();
    wait_roll();
    check("rollover period", RC, n);
    @(posedge hclk);
    check("cycle start sent", 32'h1, {31'h0, cycle_start_send});
    overlong_cycle_flag <= 1'b1;
    repeat (3) @(posedge hclk);
    rdr(32'he0, rd);
    check("master auto cleared", 32'h0010_0000, rd);
    wr(32'he0, 32'h0020_0000);
    rdr(32'he0, rd);
    check("master set refused", 32'h0010_0000, rd);
    overlong_cycle_flag <= 1'b0;
    @(posedge hclk);
    wr(32'he0, 32'h0020_0000);
    rdr(32'he0, rd);
    check("master set allowed", 32'h0030_0000, rd);
    wr(32'he4, 32'h0010_0000);
    // The timer still counts on the edge that lands the clear
    @(posedge hclk);
    rd = {20'h0, cycle_offset};
    repeat (10) @(posedge hclk);
    check("offset holds", rd, {20'h0, cycle_offset});
    wr(32'he0, 32'h0050_0000);
    n = 0;
    repeat (40)
    begin
      @(posedge hclk);
      n += int'(cycle_rollover === 1'b1);
    end
    check("no internal rollover", 32'h0, n);
    phy.pin_pulse();
    wait_roll();
    check("pin rollover", 32'h1, n);
    results();
  end
endmodule

`default_nettype wire
